// ---- logic/cad_pkg.sv ----
// shared types, constants and length tables of the addressing decoder
package cad_pkg;

   // the seventeen operand addressing modes, in seven families
   typedef enum logic [4:0] {
      MODE_INHERENT, MODE_IMMEDIATE,
      MODE_DIR_SHORT, MODE_DIR_LONG,
      MODE_IDX_NONE, MODE_IDX_SHORT, MODE_IDX_LONG,
      MODE_IND_SHORT, MODE_IND_LONG,
      MODE_INDIDX_SHORT, MODE_INDIDX_LONG,
      MODE_REL_DIRECT, MODE_REL_INDIRECT,
      MODE_BIT_DIRECT, MODE_BIT_INDIRECT,
      MODE_BITREL_DIRECT, MODE_BITREL_INDIRECT
   } cad_mode_t;

   // operation classes that the decoder itself acts on
   typedef enum logic [1:0] {
      OP_GENERIC, mask_set_op, mask_clear_op, wait_for_interrupt_op
   } cad_op_t;

   // decode request from the opcode decoder
   typedef struct packed {
      cad_mode_t   mode;        // addressing mode of the opcode
      cad_op_t     op;          // operation class
      logic        mem2mem;     // read-modify-write on memory
      logic        second_idx;  // use second index register
      logic [7:0]  idx_x;       // first index register
      logic [7:0]  idx_y;       // second index register
      logic [15:0] pc;          // pc after the last fetched byte
   } cad_req_t;

   // decode result
   typedef struct packed {
      logic [15:0] ea;          // effective operand address
      logic [7:0]  operand;     // immediate operand value
      logic [15:0] target;      // relative branch target
      logic [1:0]  nbytes;      // bytes following the opcode
      logic        imm;         // operand holds a value, not address
      logic        bad;         // long mode on memory-to-memory op
   } cad_res_t;

   localparam logic [7:0]  PAGE0_HI   = 8'h00;
   localparam logic [15:0] ADDR_STEP  = 16'h0001;
   localparam logic [1:0]  MASK_HIGH  = 2'h3;
   localparam logic [1:0]  MASK_LOW   = 2'h0;
   localparam logic [1:0]  MASK_RESET = 2'h3;
   localparam logic [15:0] IDX_SHORT_MAX = 16'h01FE;
   localparam int          BYTE_W     = 8;

   // operand bytes fetched after the opcode
   function automatic logic [1:0] cad_len(cad_mode_t m);
      unique case (m)
         MODE_INHERENT, MODE_IDX_NONE: return 2'h0;
         MODE_DIR_LONG, MODE_IDX_LONG,
         MODE_BITREL_DIRECT, MODE_BITREL_INDIRECT: return 2'h2;
         default: return 2'h1;
      endcase
   endfunction : cad_len

   // pointer bytes read from memory
   function automatic logic [1:0] cad_plen(cad_mode_t m);
      unique case (m)
         MODE_IND_LONG, MODE_INDIDX_LONG: return 2'h2;
         MODE_IND_SHORT, MODE_INDIDX_SHORT, MODE_REL_INDIRECT,
         MODE_BIT_INDIRECT, MODE_BITREL_INDIRECT: return 2'h1;
         default: return 2'h0;
      endcase
   endfunction : cad_plen

   // long submodes, refused on memory-to-memory operations
   function automatic logic cad_long(cad_mode_t m);
      return m inside {MODE_DIR_LONG, MODE_IDX_LONG, MODE_IND_LONG,
                       MODE_INDIDX_LONG};
   endfunction : cad_long

endpackage : cad_pkg

// ---- logic/cad_decoder.sv ----
// operand addressing mode decoder: fetch, pointer read, address forming
//
// What this block does
// - seventeen addressing modes in seven families
// - inherent: one byte, nothing fetched
// - immediate: next byte is the operand value
// - short direct: one address byte, page zero
// - long direct: two address bytes, full space
// - indexed: unsigned index plus instruction offset
// - no-offset indexed: index alone is address
// - short indexed: byte offset plus index
// - long indexed: word offset plus index
// - indirect: next byte points at address
// - short indirect: byte pointer, page zero
// - long indirect: one byte, word pointer
// - indirect indexed: pointer value plus index
// - short indirect indexed: byte pointer plus index
// - short submodes reach page zero, indexed ones up to 01FE
// - memory-to-memory ops only short submodes
// - mask set gives level 3, clear 0
// - relative: pc plus signed byte offset
`timescale 1ns/100ps
module cad_decoder
(
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              rst_n,
   // decode request
   input  wire logic              start,
   input  wire cad_pkg::cad_req_t req,
   // instruction byte stream
   output logic                   fetch_req,
   input  wire logic              fetch_valid,
   input  wire logic [7:0]        fetch_data,
   // pointer reads from data memory
   output logic                   mem_rd,
   output logic [15:0]            mem_addr,
   input  wire logic              mem_valid,
   input  wire logic [7:0]        mem_data,
   // decode result
   output logic                   busy,
   output logic                   done,
   output cad_pkg::cad_res_t      res,
   output logic [1:0]             mask_level
);

   // sequencer states
   typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_PTR, ST_CALC}
      cad_st_t;

   // all state of the block
   typedef struct packed {
      cad_st_t           st;         // sequencer state
      cad_pkg::cad_req_t req;        // request held for the decode
      logic [7:0]        b1;         // first byte after opcode
      logic [7:0]        b2;         // second byte after opcode
      logic [1:0]        cnt;        // bytes taken in this phase
      logic [15:0]       pv;         // pointer value, high byte first
      logic              fetch_req;  // asking for a stream byte
      logic              mem_rd;     // pointer read pending
      logic [15:0]       mem_addr;   // pointer read address
      logic              busy;       // decode in progress
      logic              done;       // result strobe
      cad_pkg::cad_res_t res;        // result
      logic [1:0]        mask_level; // interrupt mask level
   } cad_state_t;

   cad_state_t s;       // registered state
   cad_state_t next_s;  // next state
   logic [7:0] idx;     // selected index register
   logic [1:0] len;     // operand bytes of the held mode
   logic [1:0] plen;    // pointer bytes of the held mode

   // index select and mode lengths
   always_comb
   begin
      idx  = s.req.second_idx ? s.req.idx_y : s.req.idx_x;
      len  = cad_pkg::cad_len(s.req.mode);
      plen = cad_pkg::cad_plen(s.req.mode);
   end

   // next-state logic
   always_comb
   begin
      next_s      = s;
      next_s.done = 1'b0;
      unique case (s.st)
         // wait for a request; busy requests are ignored
         ST_IDLE:
         begin
            if (start)
            begin
               next_s.req  = req;
               next_s.b1   = 8'h00;
               next_s.b2   = 8'h00;
               next_s.cnt  = 2'h0;
               next_s.pv   = 16'h0000;
               next_s.busy = 1'b1;
               // mask ops act on the single opcode byte
               if (req.mode == cad_pkg::MODE_INHERENT)
               begin
                  if (req.op == cad_pkg::mask_set_op)
                     next_s.mask_level = cad_pkg::MASK_HIGH;
                  else if (req.op == cad_pkg::mask_clear_op)
                     next_s.mask_level = cad_pkg::MASK_LOW;
               end
               // long submode on memory-to-memory: refuse, fetch nothing
               if (req.mem2mem && cad_pkg::cad_long(req.mode))
                  next_s.st = ST_CALC;
               else if (cad_pkg::cad_len(req.mode) != 2'h0)
               begin
                  next_s.st        = ST_FETCH;
                  next_s.fetch_req = 1'b1;
               end
               else
                  next_s.st = ST_CALC;
            end
         end
         // take operand bytes from the stream, first byte first
         ST_FETCH:
         begin
            if (fetch_valid)
            begin
               if (s.cnt == 2'h0)
                  next_s.b1 = fetch_data;
               else
                  next_s.b2 = fetch_data;
               next_s.cnt = s.cnt + 2'h1;
               if (s.cnt + 2'h1 == len)
               begin
                  next_s.fetch_req = 1'b0;
                  next_s.cnt       = 2'h0;
                  if (plen != 2'h0)
                  begin
                     // pointer address is always the first byte
                     next_s.st       = ST_PTR;
                     next_s.mem_rd   = 1'b1;
                     next_s.mem_addr = {cad_pkg::PAGE0_HI,
                        (s.cnt == 2'h0) ? fetch_data : s.b1};
                  end
                  else
                     next_s.st = ST_CALC;
               end
            end
         end
         // read the pointer, a byte or a high-first word
         ST_PTR:
         begin
            if (mem_valid)
            begin
               next_s.pv  = {s.pv[7:0], mem_data};
               next_s.cnt = s.cnt + 2'h1;
               if (s.cnt + 2'h1 == plen)
               begin
                  next_s.mem_rd = 1'b0;
                  next_s.cnt    = 2'h0;
                  next_s.st     = ST_CALC;
               end
               else
                  next_s.mem_addr = s.mem_addr + cad_pkg::ADDR_STEP;
            end
         end
         // form the result from gathered bytes
         ST_CALC:
         begin
            next_s.st          = ST_IDLE;
            next_s.busy        = 1'b0;
            next_s.done        = 1'b1;
            next_s.res         = '0;
            next_s.res.nbytes  = len;
            next_s.res.bad     = s.req.mem2mem &&
                                 cad_pkg::cad_long(s.req.mode);
            unique case (s.req.mode)
               cad_pkg::MODE_INHERENT: ;
               cad_pkg::MODE_IMMEDIATE:
               begin
                  next_s.res.operand = s.b1;
                  next_s.res.imm     = 1'b1;
               end
               cad_pkg::MODE_DIR_SHORT, cad_pkg::MODE_BIT_DIRECT:
                  next_s.res.ea = {cad_pkg::PAGE0_HI, s.b1};
               cad_pkg::MODE_DIR_LONG:
                  next_s.res.ea = {s.b1, s.b2};
               cad_pkg::MODE_IDX_NONE:
                  next_s.res.ea = {cad_pkg::PAGE0_HI, idx};
               cad_pkg::MODE_IDX_SHORT:
                  next_s.res.ea = {cad_pkg::PAGE0_HI, idx} +
                     {cad_pkg::PAGE0_HI, s.b1};
               cad_pkg::MODE_IDX_LONG:
                  next_s.res.ea = {cad_pkg::PAGE0_HI, idx} +
                     {s.b1, s.b2};
               cad_pkg::MODE_IND_SHORT, cad_pkg::MODE_IND_LONG,
               cad_pkg::MODE_BIT_INDIRECT:
                  next_s.res.ea = s.pv;
               cad_pkg::MODE_INDIDX_SHORT, cad_pkg::MODE_INDIDX_LONG:
                  next_s.res.ea = s.pv +
                     {cad_pkg::PAGE0_HI, idx};
               cad_pkg::MODE_REL_DIRECT:
                  next_s.res.target = s.req.pc +
                     {{cad_pkg::BYTE_W{s.b1[7]}}, s.b1};
               cad_pkg::MODE_REL_INDIRECT:
                  next_s.res.target = s.req.pc +
                     {{cad_pkg::BYTE_W{s.pv[7]}}, s.pv[7:0]};
               cad_pkg::MODE_BITREL_DIRECT:
               begin
                  next_s.res.ea     = {cad_pkg::PAGE0_HI, s.b1};
                  next_s.res.target = s.req.pc +
                     {{cad_pkg::BYTE_W{s.b2[7]}}, s.b2};
               end
               cad_pkg::MODE_BITREL_INDIRECT:
               begin
                  next_s.res.ea     = s.pv;
                  next_s.res.target = s.req.pc +
                     {{cad_pkg::BYTE_W{s.b2[7]}}, s.b2};
               end
               default: ; // illegal mode codes give a zero result except nbytes of 1
            endcase
            // a refused request reports no address, whatever the index
            if (next_s.res.bad)
               next_s.res.ea = 16'h0000;
         end
      endcase
   end

   // state register
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s            <= '0;
         s.st         <= ST_IDLE;
         s.mask_level <= cad_pkg::MASK_RESET;
      end
      else
         s <= next_s;
   end

   // outputs straight from the state flops
   assign fetch_req  = s.fetch_req;
   assign mem_rd     = s.mem_rd;
   assign mem_addr   = s.mem_addr;
   assign busy       = s.busy;
   assign done       = s.done;
   assign res        = s.res;
   assign mask_level = s.mask_level;

   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   // request with nothing to fetch ends two edges later
   sequence seq_quick_done;
      ##2 done;
   endsequence

   AST_INHERENT_ONE_BYTE:
   assert property (start && !busy && req.mode == cad_pkg::MODE_INHERENT
      |-> seq_quick_done ##0 (res.nbytes == 2'h0) ##0 !fetch_req)
      else $error("inherent decode fetched bytes");

   AST_IMMEDIATE_VALUE:
   assert property (done && s.req.mode == cad_pkg::MODE_IMMEDIATE
      |-> res.imm && res.nbytes == 2'h1 && res.operand == s.b1)
      else $error("immediate operand not the fetched byte");

   AST_SHORT_DIRECT_PAGE0:
   assert property (done && s.req.mode == cad_pkg::MODE_DIR_SHORT
      |-> res.ea[15:8] == cad_pkg::PAGE0_HI && res.nbytes == 2'h1)
      else $error("short direct left page zero");

   AST_LONG_DIRECT_WORD:
   assert property (done && s.req.mode == cad_pkg::MODE_DIR_LONG
      && !res.bad |-> res.ea == {s.b1, s.b2} && res.nbytes == 2'h2)
      else $error("long direct address wrong");

   AST_NO_OFFSET_INDEX:
   assert property (start && !busy && !req.second_idx
      && req.mode == cad_pkg::MODE_IDX_NONE
      |-> seq_quick_done ##0 (res.ea == {cad_pkg::PAGE0_HI,
          $past(req.idx_x, 2)}))
      else $error("no-offset index address wrong");

   AST_SHORT_INDEX_RANGE:
   assert property (done && s.req.mode == cad_pkg::MODE_IDX_SHORT
      |-> res.ea <= cad_pkg::IDX_SHORT_MAX
          && res.ea == {cad_pkg::PAGE0_HI, s.b1} + {cad_pkg::PAGE0_HI,
             (s.req.second_idx ? s.req.idx_y : s.req.idx_x)})
      else $error("short index sum wrong");

   AST_INDIRECT_ONE_BYTE:
   assert property (done && (s.req.mode == cad_pkg::MODE_IND_LONG
      || s.req.mode == cad_pkg::MODE_IND_SHORT) && !res.bad
      |-> res.nbytes == 2'h1 && res.ea == s.pv)
      else $error("indirect used wrong length or pointer");

   AST_M2M_LONG_REFUSED:
   assert property (start && !busy && req.mem2mem
      && cad_pkg::cad_long(req.mode)
      |-> !fetch_req [*3] ##0 done ##0 (res.bad && res.ea == 16'h0000))
      else $error("long mode on memory op not refused");

   AST_MASK_SET_LEVEL:
   assert property (start && !busy && req.mode == cad_pkg::MODE_INHERENT
      && req.op == cad_pkg::mask_set_op |=> mask_level == cad_pkg::MASK_HIGH)
      else $error("mask set did not reach level 3");

   AST_MASK_CLEAR_LEVEL:
   assert property (start && !busy && req.mode == cad_pkg::MODE_INHERENT
      && req.op == cad_pkg::mask_clear_op |=> mask_level == cad_pkg::MASK_LOW)
      else $error("mask clear did not reach level 0");

endmodule : cad_decoder

// ---- test/cad_mem_model.sv ----
// behavioural instruction stream and pointer memory beside the decoder
`timescale 1ns/100ps
module cad_mem_model
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // bench controls: answer delay, request strobe, stream bytes
   input  wire logic [1:0]  lat,
   input  wire logic        start,
   input  wire logic [15:0] strm,
   // instruction stream
   input  wire logic        fetch_req,
   output logic             fetch_valid,
   output logic [7:0]       fetch_data,
   // pointer reads
   input  wire logic        mem_rd,
   input  wire logic [15:0] mem_addr,
   output logic             mem_valid,
   output logic [7:0]       mem_data
);
   logic [7:0] mem [0:511]; // data memory image, bench may overwrite
   logic [1:0] wcnt;        // cycles the pending request has waited
   logic       pos;         // next stream byte, 0 is the first
   logic [7:0] last;        // last byte handed out

   // answer once the request has waited lat cycles
   assign fetch_valid = fetch_req && (wcnt >= lat);
   assign mem_valid   = mem_rd && (wcnt >= lat);
   // idle lines show the inverse of the last byte, never a stale copy
   assign fetch_data  = !fetch_valid ? ~last : pos ? strm[7:0] : strm[15:8];
   assign mem_data    = mem_valid ? mem[mem_addr[8:0]] : ~last;

   // known pattern so every pointer read returns a defined byte
   initial
   begin
      for (int i = 0; i < 512; i++)
         mem[i] = 8'(i) ^ 8'h5A;
   end

   // wait counter and stream position
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wcnt <= 2'h0;
         pos  <= 1'b0;
         last <= 8'h00;
      end
      else
      begin
         // a taken byte or no request restarts the wait
         if (fetch_valid || mem_valid || !(fetch_req || mem_rd))
            wcnt <= 2'h0;
         else if (wcnt != 2'h3)
            wcnt <= wcnt + 2'h1;
         // stream bytes go high byte first
         if (fetch_valid)
         begin
            pos  <= !pos;
            last <= fetch_data;
         end
         else if (mem_valid)
            last <= mem_data;
         // new instruction restarts the stream
         if (start)
            pos <= 1'b0;
      end
   end
endmodule : cad_mem_model

// ---- test/test_cad_decoder.sv ----
// self-checking bench of the operand addressing mode decoder
`timescale 1ns/100ps
module test_cad_decoder;
   logic              mclk, rst_n, start;   // clock, reset, strobe
   cad_pkg::cad_req_t req, r;               // driven and staged request
   logic              fetch_req, fetch_valid, mem_rd, mem_valid;
   logic [7:0]        fetch_data, mem_data; // memory side bytes
   logic [15:0]       mem_addr, strm, ncyc; // address, stream, latency
   logic [1:0]        lat, mask_level;      // model delay, mask level
   logic              busy, done;           // block status
   cad_pkg::cad_res_t res;                  // decode result
   int                n_mismatch, checked;  // counters

   cad_decoder DUT (.mclk(mclk), .rst_n(rst_n), .start(start), .req(req),
      .fetch_req(fetch_req), .fetch_valid(fetch_valid),
      .fetch_data(fetch_data), .mem_rd(mem_rd), .mem_addr(mem_addr),
      .mem_valid(mem_valid), .mem_data(mem_data), .busy(busy),
      .done(done), .res(res), .mask_level(mask_level));
   cad_mem_model u_mem (.mclk(mclk), .rst_n(rst_n), .lat(lat),
      .start(start), .strm(strm), .fetch_req(fetch_req),
      .fetch_valid(fetch_valid), .fetch_data(fetch_data),
      .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_valid(mem_valid),
      .mem_data(mem_data));

   // 25 MHz clock
   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   // compare one result, widened to a word
   task automatic chk_w(input string nm, input logic [15:0] e, g);
      checked++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_w

   // counts, verdict, end of run
   task automatic conclude;
      $display("mismatches %0d of %0d checks", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : conclude

   // hand one request over and wait a bounded time for done
   task automatic issue(input cad_pkg::cad_mode_t m,
                        input logic [7:0] x, input logic [15:0] s);
      @(posedge mclk);
      #1;
      r.mode = m;
      r.idx_x = x;
      req = r;
      strm = s;
      start = 1'b1;
      @(posedge mclk);
      #1;
      start = 1'b0;
      ncyc = 16'h0001;
      while (done !== 1'b1 && ncyc < 16'h0040)
      begin
         @(posedge mclk);
         #1;
         ncyc++;
      end
      // a request that never finishes is a mismatch of its own
      if (done !== 1'b1)
      begin
         n_mismatch++;
         $display("[FAIL] done expected 1 seen %b", done);
      end
   endtask : issue

   // mask clear, set and wait are single byte, answered in two cycles
   task automatic t_mask;
      chk_w("mask after reset", 16'h0003, {14'h0, mask_level});
      r.op = cad_pkg::mask_clear_op;
      issue(cad_pkg::MODE_INHERENT, 8'h00, 16'h0000);
      chk_w("mask clear", 16'h0000, {14'h0, mask_level});
      chk_w("inherent cycles", 16'h0002, ncyc);
      chk_w("inherent bytes", 16'h0000, {14'h0, res.nbytes});
      r.op = cad_pkg::mask_set_op;
      issue(cad_pkg::MODE_INHERENT, 8'h00, 16'h0000);
      chk_w("mask set", 16'h0003, {14'h0, mask_level});
      r.op = cad_pkg::wait_for_interrupt_op;
      issue(cad_pkg::MODE_INHERENT, 8'h00, 16'h0000);
      chk_w("mask kept", 16'h0003, {14'h0, mask_level});
      chk_w("busy at done", 16'h0000, {15'h0, busy});
      r.op = cad_pkg::OP_GENERIC;
   endtask : t_mask

   // immediate value and both direct submodes, long one answered slowly
   task automatic t_direct;
      issue(cad_pkg::MODE_IMMEDIATE, 8'h00, 16'h5A00);
      chk_w("imm value", 16'h005A, {8'h0, res.operand});
      chk_w("imm flag", 16'h0001, {15'h0, res.imm});
      issue(cad_pkg::MODE_DIR_SHORT, 8'h00, 16'h8000);
      chk_w("short direct", 16'h0080, res.ea);
      lat = 2'h2;
      issue(cad_pkg::MODE_DIR_LONG, 8'h00, 16'h1234);
      chk_w("long direct", 16'h1234, res.ea);
      lat = 2'h0;
   endtask : t_direct

   // indexed submodes, second index and carry into bit 8
   task automatic t_index;
      issue(cad_pkg::MODE_IDX_NONE, 8'hF0, 16'h0000);
      chk_w("no offset ea", 16'h00F0, res.ea);
      chk_w("no offset cycles", 16'h0002, ncyc);
      r.second_idx = 1'b1;
      r.idx_y = 8'hFF;
      issue(cad_pkg::MODE_IDX_SHORT, 8'h01, 16'hFF00);
      chk_w("short idx ea", 16'h01FE, res.ea);
      r.second_idx = 1'b0;
      issue(cad_pkg::MODE_IDX_LONG, 8'h10, 16'h1230);
      chk_w("long idx ea", 16'h1240, res.ea);
   endtask : t_index

   // indirect and indirect indexed, word pointer across page end
   task automatic t_indirect;
      u_mem.mem[9'h040] = 8'h9C;
      issue(cad_pkg::MODE_IND_SHORT, 8'h00, 16'h4000);
      chk_w("short ind ea", 16'h009C, res.ea);
      chk_w("short ind cycles", 16'h0004, ncyc);
      u_mem.mem[9'h0FF] = 8'hAB;
      u_mem.mem[9'h100] = 8'hCD;
      issue(cad_pkg::MODE_IND_LONG, 8'h00, 16'hFF00);
      chk_w("long ind ea", 16'hABCD, res.ea);
      u_mem.mem[9'h050] = 8'hF0;
      issue(cad_pkg::MODE_INDIDX_SHORT, 8'h20, 16'h5000);
      chk_w("short indidx", 16'h0110, res.ea);
      r.second_idx = 1'b1;
      r.idx_y = 8'h05;
      u_mem.mem[9'h060] = 8'h20;
      u_mem.mem[9'h061] = 8'h00;
      issue(cad_pkg::MODE_INDIDX_LONG, 8'h00, 16'h6000);
      chk_w("long indidx", 16'h2005, res.ea);
      r.second_idx = 1'b0;
   endtask : t_indirect

   // memory-to-memory ops refuse every long submode
   task automatic t_m2m;
      cad_pkg::cad_mode_t lm [4];
      logic [1:0]         lb [4];
      lm = '{cad_pkg::MODE_DIR_LONG, cad_pkg::MODE_IDX_LONG,
             cad_pkg::MODE_IND_LONG, cad_pkg::MODE_INDIDX_LONG};
      lb = '{2'h2, 2'h2, 2'h1, 2'h1};
      r.mem2mem = 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         issue(lm[i], 8'h33, 16'h1234);
         chk_w("refused flag", 16'h0001, {15'h0, res.bad});
         chk_w("refused ea", 16'h0000, res.ea);
         chk_w("refused cycles", 16'h0002, ncyc);
         chk_w("refused bytes", {14'h0, lb[i]}, {14'h0, res.nbytes});
      end
      issue(cad_pkg::MODE_DIR_SHORT, 8'h00, 16'h8000);
      chk_w("short accepted", 16'h0000, {15'h0, res.bad});
      chk_w("short m2m ea", 16'h0080, res.ea);
      r.mem2mem = 1'b0;
   endtask : t_m2m

   // relative targets with backward and indirect forward offsets
   task automatic t_rel;
      r.pc = 16'h1000;
      issue(cad_pkg::MODE_REL_DIRECT, 8'h00, 16'h8000);
      chk_w("rel direct", 16'h0F80, res.target);
      r.pc = 16'h2000;
      u_mem.mem[9'h070] = 8'h7F;
      issue(cad_pkg::MODE_REL_INDIRECT, 8'h00, 16'h7000);
      chk_w("rel indirect", 16'h207F, res.target);
      r.pc = 16'h0000;
   endtask : t_rel

   // every mode once, one cycle late answers, byte count per mode
   task automatic t_modes;
      logic [1:0] nb [17];
      nb = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h0, 2'h1, 2'h2, 2'h1, 2'h1,
             2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2};
      lat = 2'h1;
      for (int i = 0; i < 17; i++)
      begin
         issue(cad_pkg::cad_mode_t'(5'(i)), 8'h03, 16'h0102);
         chk_w("mode done", 16'h0001, {15'h0, ncyc < 16'h0040});
         chk_w("mode bytes", {14'h0, nb[i]}, {14'h0, res.nbytes});
         chk_w("mode imm", {15'h0, i == 1}, {15'h0, res.imm});
      end
      lat = 2'h0;
   endtask : t_modes

   // watchdog well beyond the few hundred cycles the run needs
   initial
   begin
      repeat (5000) @(posedge mclk);
      n_mismatch++;
      conclude;
   end

   // reset, then the scenarios
   initial
   begin
      rst_n = 1'b0;
      start = 1'b0;
      req = '0;
      r = '0;
      lat = 2'h0;
      strm = 16'h0000;
      n_mismatch = 0;
      checked = 0;
      repeat (12) @(posedge mclk);
      #1;
      rst_n = 1'b1;
      t_mask;
      t_direct;
      t_index;
      t_indirect;
      t_m2m;
      t_rel;
      t_modes;
      conclude;
   end
endmodule : test_cad_decoder
